// ---- dv/dspt_stage.sv ----
// Power stage model loading output pin A.
// Assumes a pull-down on the pin while nobody drives it.
`timescale 1ns/1ps
module dspt_stage (
  // Pin from the timer
  input  wire logic out_a,
  input  wire logic oe_a,
  // Level seen by the load
  output logic      level_a
);
  // Released pin falls to the pull-down
  assign level_a = oe_a ? out_a : 1'b0;
endmodule

// ---- dv/tb_top.sv ----
// Testbench for the dual-slope timer: reset, top turn, duty table.
// Assumes a 250 MHz clock and the stage model on pin A.
`timescale 1ns/1ps
module tb_top;
  import dspt_pkg::*;
  logic        clock = 0;
  logic        reset = 1;
  dspt_cfg_t   cfg = '0;
  logic [2:0]  ts8 = PS_8;
  logic        dir_a = 0;
  logic        wr_a = 0;
  logic        wr_cap = 0;
  logic [15:0] wdata = '0;
  dspt_flags_t fclr = '0;
  dspt_flags_t flags;
  logic [15:0] cnt, cmp_a;
  logic        down, t8, oa, oa_oe, ob, ob_oe, lvl;
  int          err_total = 0;
  int          n_tests = 0;
  // Clock
  always #2 clock = ~clock;
  dspt_timer DUT (.clock(clock), .reset(reset), .cfg(cfg), .tick_select_eight(ts8),
    .pin_direction_a(dir_a), .pin_direction_b(dir_a), .compare_write_a(wr_a),
    .compare_write_b(wr_a), .capture_write(wr_cap), .write_data(wdata), .flag_clear(fclr),
    .count_value(cnt), .counting_down(down), .flags(flags), .compare_value_a(cmp_a),
    .tick_eight(t8), .compare_output_a(oa), .compare_output_a_oe(oa_oe),
    .compare_output_b(ob), .compare_output_b_oe(ob_oe));
  dspt_stage STAGE (.out_a(oa), .oe_a(oa_oe), .level_a(lvl));
  // Edges, then a fixed drive delay
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic cap, input logic [15:0] d);
    wdata = d;
    wr_cap = cap;
    wr_a = !cap;
    step(1);
    wr_cap = 0;
    wr_a = 0;
    step(1);
  endtask
  task automatic clr();
    fclr = '1;
    step(1);
    fclr = '0;
  endtask
  task automatic t_reset();
    step(20);
    chk("count", 16'h0000, cnt);
    chk("flags", 16'h0000, {12'h000, flags});
    chk("pin", 16'h0000, {14'h0000, oa, oa_oe});
  endtask
  // Fixed 8-bit top: turn, masking, bottom flag
  task automatic t_top();
    int i;
    cfg.waveform_select = WS_PC8;
    wr(0, 16'habcd);
    cfg.tick_select = PS_1;
    for (i = 0; i < 600 && cnt !== TOP_8BIT; i++) step(1);
    step(1);
    chk("after top", 16'h00fe, cnt);
    clr();
    step(4);
    chk("masked", 16'h00cd, cmp_a);
    step(260);
    chk("ovf", 16'h0001, {15'h0000, flags.overflow_flag});
  endtask
  // Count high cycles of the load over 32 ticks
  task automatic t_pwm(input logic [3:0] ws, input logic [1:0] om, input logic [15:0] top,
                       input logic [15:0] cmp, input logic d, input int hi);
    int          i;
    logic [15:0] h, hb, n8, nd;
    logic        tf;
    cfg.waveform_select = ws;
    cfg.output_mode_a = om;
    cfg.output_mode_b = om;
    dir_a = d;
    wr(1, top);
    wr(0, cmp);
    step(100);
    clr();
    h = '0;
    hb = '0;
    n8 = '0;
    nd = '0;
    for (i = 0; i < 32; i++) begin
      h += lvl;
      hb += ob & ob_oe;
      n8 += t8;
      nd += down;
      step(1);
    end
    tf = (ws == WS_PFC_CMPA) ? flags.compare_match_flag_a : flags.capture_flag;
    chk("high", hi[15:0], h);
    chk("high b", (om == OM_TOGGLE) ? 16'h0000 : hi[15:0], hb);
    chk("oe", {14'h0000, d, d}, {14'h0000, oa_oe, ob_oe});
    chk("down", (16'h0010 / top) * (top - 16'h0001), nd);
    chk("tick eight", 16'h0004, n8);
    chk("ovf", 16'h0001, {15'h0000, flags.overflow_flag});
    chk("top flag", 16'h0001, {15'h0000, tf});
    chk("flag b", 16'h0001, {15'h0000, flags.compare_match_flag_b});
  endtask
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence; tops stay at 0x0003 or more
  initial begin
    step(8);
    reset = 0;
    t_reset();
    t_top();
    t_pwm(WS_PC_CAP, OM_NONINV, 16'h0010, 16'h0004, 1, 8);
    t_pwm(WS_PC_CAP, OM_INV, 16'h0010, 16'h0004, 1, 24);
    t_pwm(WS_PC_CAP, OM_NONINV, 16'h0010, 16'h0000, 1, 0);
    t_pwm(WS_PC_CAP, OM_NONINV, 16'h0010, 16'h0010, 1, 32);
    t_pwm(WS_PC_CAP, OM_INV, 16'h0010, 16'h0010, 1, 0);
    t_pwm(WS_PC_CAP, OM_NONINV, 16'h0010, 16'h0010, 0, 0);
    t_pwm(WS_PC_CAP, OM_OFF, 16'h0010, 16'h0010, 1, 0);
    t_pwm(WS_PFC_CMPA, OM_TOGGLE, 16'h0008, 16'h0008, 1, 16);
    t_pwm(WS_PFC_CAP, OM_NONINV, 16'h0010, 16'h0004, 1, 8);
    test_done();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    test_done();
  end
endmodule

// ---- hdl/dspt_out_ch.sv ----
// One compare output channel: buffered compare value, match detect,
// waveform output and pin gating.
// Assumes count, direction and top arrive from the counter core.
`timescale 1ns/1ps
module dspt_out_ch #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Software write of the compare value
  input  wire logic             write_en,
  input  wire logic [WIDTH-1:0] write_data,
  input  wire logic [WIDTH-1:0] write_mask,
  // Counter state and channel settings
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count_value,
  input  wire logic [WIDTH-1:0] top_value,
  input  wire logic             counting_up,
  input  wire logic             pwm_mode,
  input  wire logic             toggle_ok,
  input  wire logic [1:0]       output_mode,
  input  wire logic             pin_direction_bit,
  // Results
  output logic      [WIDTH-1:0] compare_value_reg,
  output logic                  match,
  output logic                  compare_output,
  output logic                  pin_out,
  output logic                  pin_oe
);
  import dspt_pkg::*;

  initial begin
    if (WIDTH < 2) $error("dspt_out_ch width too small");
  end

  logic [WIDTH-1:0] buffer_reg;
  logic             rising;

  // ----------------------------------------------------------------
  // Buffer and active compare register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buffer_reg        <= '0;
      compare_value_reg <= '0;
    end else begin
      if (write_en) buffer_reg <= write_data & write_mask; // [RULE12]
      if (load) compare_value_reg <= buffer_reg;
    end
  end

  // Match only when compare is reachable, at or below top [RULE13] [RULE17]
  assign match = tick && pwm_mode && (count_value == compare_value_reg)
                 && (compare_value_reg <= top_value);

  // Turn at top belongs to the falling slope, so compare equal top stays set in non-inverted mode
  assign rising = counting_up && (count_value != top_value); // [RULE14]

  // ----------------------------------------------------------------
  // Waveform register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      compare_output <= 1'b0; // [RULE23]
    end else if (match) begin
      case (output_mode)
        OM_NONINV: compare_output <= !rising;             // [RULE5] [RULE6] [RULE14]
        OM_INV:    compare_output <= rising;              // [RULE5] [RULE6] [RULE14]
        OM_TOGGLE: compare_output <= compare_output ^ toggle_ok; // [RULE15]
        default:   compare_output <= compare_output;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive: connected by mode, toggle_ok and direction bit
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_oe  <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      pin_oe  <= pin_direction_bit; // [RULE16]
      pin_out <= 1'b0;
      if (output_mode != OM_OFF && !(output_mode == OM_TOGGLE && !toggle_ok)) begin // [RULE22]
        pin_out <= compare_output;
      end
    end
  end

endmodule

// ---- hdl/dspt_pkg.sv ----
// Package for the dual-slope 16-bit PWM timer: mode codes, tops, widths,
// prescaler settings and carrier structs.
// Assumes one clock domain; no bus, all control arrives on plain ports.
package dspt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W   = 16;
  localparam int MODE_W  = 4;
  localparam int OMODE_W = 2;
  localparam int PSEL_W  = 3;
  localparam int PDIV_W  = 10;

  // ----------------------------------------------------------------
  // Waveform select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] WS_PC8      = 4'h1;
  localparam logic [3:0] WS_PC9      = 4'h2;
  localparam logic [3:0] WS_PC10     = 4'h3;
  localparam logic [3:0] WS_PFC_CAP  = 4'h8;
  localparam logic [3:0] WS_PFC_CMPA = 4'h9;
  localparam logic [3:0] WS_PC_CAP   = 4'ha;
  localparam logic [3:0] WS_PC_CMPA  = 4'hb;

  // ----------------------------------------------------------------
  // Fixed tops and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] BOTTOM    = 16'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] MIN_TOP   = 16'h0003;

  // ----------------------------------------------------------------
  // Output mode field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_NONINV = 2'h2;
  localparam logic [1:0] OM_INV    = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler selects and divide counts
  // ----------------------------------------------------------------
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_1    = 3'h1;
  localparam logic [2:0] PS_8    = 3'h2;
  localparam logic [2:0] PS_64   = 3'h3;
  localparam logic [2:0] PS_256  = 3'h4;
  localparam logic [2:0] PS_1024 = 3'h5;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV64_MASK   = 10'h03f;
  localparam logic [9:0] DIV256_MASK  = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] waveform_select;
    logic [1:0] output_mode_a;
    logic [1:0] output_mode_b;
    logic [2:0] tick_select;
  } dspt_cfg_t;

  typedef struct packed {
    logic overflow_flag;
    logic compare_match_flag_a;
    logic compare_match_flag_b;
    logic capture_flag;
  } dspt_flags_t;

  typedef enum logic [1:0] {
    DSPT_UP   = 2'b00,
    DSPT_HOLD = 2'b01,
    DSPT_DOWN = 2'b11
  } dspt_dir_t;

endpackage

// ---- hdl/dspt_prescaler.sv ----
// Shared prescaler: one free divider, two independent tick selects.
// Assumes the timers are clocked by the same clock and use the ticks as enables.
`timescale 1ns/1ps
module dspt_prescaler #(
  parameter int NUM_TIMERS = 2
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // Per-timer divider select
  input  wire logic [3*NUM_TIMERS-1:0] tick_select,
  // Per-timer tick enables
  output logic      [NUM_TIMERS-1:0]   timer_tick
);
  import dspt_pkg::*;

  initial begin
    if (NUM_TIMERS < 1) $error("dspt_prescaler needs at least one timer");
  end

  logic [PDIV_W-1:0] div_reg;

  // ----------------------------------------------------------------
  // Free-running divider shared by all timers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_reg + 10'h001;
    end
  end

  // Each timer picks its own rate from the shared divider [RULE21]
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tick
      logic [2:0] sel;
      logic       tick_reg;
      assign sel = tick_select[3*g +: 3];
      assign timer_tick[g] = tick_reg;
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          tick_reg <= 1'b0;
        end else begin
          case (sel)
            PS_1:    tick_reg <= 1'b1;
            PS_8:    tick_reg <= (div_reg & DIV8_MASK) == DIV8_MASK;
            PS_64:   tick_reg <= (div_reg & DIV64_MASK) == DIV64_MASK;
            PS_256:  tick_reg <= (div_reg & DIV256_MASK) == DIV256_MASK;
            PS_1024: tick_reg <= (div_reg & DIV1024_MASK) == DIV1024_MASK;
            default: tick_reg <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

endmodule

// ---- hdl/dspt_timer.sv ----
// Dual-slope 16-bit PWM timer: counter core, top select, flags and two
// compare channels, with a shared prescaler for this and an 8-bit timer.
// Assumes all inputs synchronous to clock; software writes arrive as strobes.
//
// Contract
// RULE1: Codes 1,2,3,A,B run phase correct: up to top, down to zero.
// RULE2: Phase correct top is 0x00FF/0x01FF/0x03FF, capture reg, or compare A.
// RULE3: Codes 8,9 run phase-and-frequency correct; top from capture or compare A.
// RULE4: Counter holds top for exactly one tick, then counts down.
// RULE5: Output mode 2 gives non-inverted PWM, mode 3 inverted.
// RULE6: Non-inverting clears on up match, sets on down match; inverting opposite.
// RULE7: Software keeps a register top between 0x0003 and 0xFFFF.
// RULE8: Phase correct sets overflow flag at every tick reaching zero.
// RULE9: Phase correct loads compares at top and sets compare-A or capture flag.
// RULE10: Phase-frequency correct loads compares at zero with overflow flag.
// RULE11: Phase-frequency correct sets compare-A or capture flag at top.
// RULE12: Fixed top masks compare writes above the resolution to zero.
// RULE13: Compare above top never matches.
// RULE14: Compare zero gives low, equal top gives high, non-inverted.
// RULE15: Compare A as top with mode 1 toggles output A each match.
// RULE16: Waveform reaches pin only while the direction bit is output.
// RULE17: Channel flag set whenever counter matches its compare value.
// RULE18: Phase correct falling slope uses old top, rising slope new top.
// RULE19: Software prefers phase-frequency correct when changing top live.
// RULE20: Counter synchronous, advances only on timer tick.
// RULE21: Both timers share one prescaler with own divider 1,8,64,256,1024.
// RULE22: Output mode 0 disconnects the compare output from the pin.
// RULE23: After reset count zero, up, flags clear, outputs low, disconnected.
`timescale 1ns/1ps
module dspt_timer (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Configuration
  input  dspt_pkg::dspt_cfg_t         cfg,
  input  wire logic [2:0]             tick_select_eight,
  input  wire logic                   pin_direction_a,
  input  wire logic                   pin_direction_b,
  // Software writes
  input  wire logic                   compare_write_a,
  input  wire logic                   compare_write_b,
  input  wire logic                   capture_write,
  input  wire logic [15:0]            write_data,
  // Flag clears, one bit per flag
  input  dspt_pkg::dspt_flags_t       flag_clear,
  // Status
  output logic      [15:0]            count_value,
  output logic                        counting_down,
  output dspt_pkg::dspt_flags_t       flags,
  output logic      [15:0]            compare_value_a,
  output logic                        tick_eight,
  // Pins
  output logic                        compare_output_a,
  output logic                        compare_output_a_oe,
  output logic                        compare_output_b,
  output logic                        compare_output_b_oe
);
  import dspt_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dspt_dir_t   dir_reg, dir_next;
  logic [15:0] cnt_next;
  logic [15:0] capture_top_reg;
  logic [15:0] cmp_b;
  logic [15:0] top_value;
  logic [15:0] write_mask;
  logic [1:0]  ticks;
  logic        timer_tick;
  logic        pc_mode, pfc_mode, pwm_mode, top_from_a, top_from_cap;
  logic        at_top, at_bottom, load_cmp;
  logic        match_a, match_b;
  logic        wave_a, wave_b;
  logic [15:0] cmp_a_int;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    pc_mode  = 1'b0;
    pfc_mode = 1'b0;
    case (cfg.waveform_select)
      WS_PC8, WS_PC9, WS_PC10, WS_PC_CAP, WS_PC_CMPA: pc_mode = 1'b1; // [RULE1]
      WS_PFC_CAP, WS_PFC_CMPA:                       pfc_mode = 1'b1; // [RULE3]
      default: ;
    endcase
  end
  assign pwm_mode     = pc_mode || pfc_mode;
  assign top_from_a   = cfg.waveform_select == WS_PC_CMPA || cfg.waveform_select == WS_PFC_CMPA;
  assign top_from_cap = cfg.waveform_select == WS_PC_CAP || cfg.waveform_select == WS_PFC_CAP;

  // Top source selection [RULE2] [RULE3]
  always_comb begin
    case (cfg.waveform_select)
      WS_PC8:                 top_value = TOP_8BIT;
      WS_PC9:                 top_value = TOP_9BIT;
      WS_PC10:                top_value = TOP_10BIT;
      WS_PC_CAP, WS_PFC_CAP:  top_value = capture_top_reg;
      WS_PC_CMPA, WS_PFC_CMPA: top_value = cmp_a_int;
      default:                top_value = 16'hffff;
    endcase
  end

  // Fixed tops mask compare writes [RULE12]
  always_comb begin
    case (cfg.waveform_select)
      WS_PC8:  write_mask = TOP_8BIT;
      WS_PC9:  write_mask = TOP_9BIT;
      WS_PC10: write_mask = TOP_10BIT;
      default: write_mask = 16'hffff;
    endcase
  end

  // ----------------------------------------------------------------
  // Shared prescaler for this timer and the 8-bit timer
  // ----------------------------------------------------------------
  dspt_prescaler #(.NUM_TIMERS(2)) u_prescaler (
    .clock       (clock),
    .reset       (reset),
    .tick_select ({tick_select_eight, cfg.tick_select}),
    .timer_tick  (ticks)
  );
  assign timer_tick = ticks[0]; // [RULE21]

  // ----------------------------------------------------------------
  // Capture register used as top (not double buffered)
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      capture_top_reg <= 16'h0000;
    end else if (capture_write) begin
      capture_top_reg <= write_data; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Counter direction and next value
  // ----------------------------------------------------------------
  assign at_top    = timer_tick && pwm_mode && count_value == top_value;
  assign at_bottom = timer_tick && pwm_mode && count_value == BOTTOM;

  always_comb begin
    dir_next = dir_reg;
    cnt_next = count_value;
    case (dir_reg)
      DSPT_UP: begin
        if (count_value >= top_value) begin
          dir_next = DSPT_HOLD; // [RULE4]
          cnt_next = count_value - 16'h0001;
        end else begin
          cnt_next = count_value + 16'h0001;
        end
      end
      DSPT_HOLD: begin
        dir_next = DSPT_DOWN;
        cnt_next = count_value - 16'h0001;
        if (count_value == 16'h0001) dir_next = DSPT_UP;
      end
      DSPT_DOWN: begin
        if (count_value == 16'h0001) dir_next = DSPT_UP;
        cnt_next = count_value - 16'h0001;
      end
      default: begin
        dir_next = DSPT_UP;
        cnt_next = CNT_RST;
      end
    endcase
  end

  // Counter advances only on the tick [RULE20] [RULE1] [RULE18]
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_value <= CNT_RST; // [RULE23]
      dir_reg     <= DSPT_UP;
    end else if (timer_tick && pwm_mode) begin
      count_value <= cnt_next;
      dir_reg     <= dir_next;
    end else if (!pwm_mode) begin
      count_value <= CNT_RST;
      dir_reg     <= DSPT_UP;
    end
  end

  // Direction status registered from the next direction
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      counting_down <= 1'b0;
    end else begin
      counting_down <= dir_next != DSPT_UP && timer_tick && pwm_mode ? 1'b1 :
                       (timer_tick && pwm_mode) ? 1'b0 : counting_down;
    end
  end

  // Compare load point differs by family [RULE9] [RULE10]
  assign load_cmp = (pc_mode && at_top) || (pfc_mode && at_bottom) || !pwm_mode;

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  dspt_out_ch #(.WIDTH(16)) u_ch_a (
    .clock             (clock),
    .reset             (reset),
    .write_en          (compare_write_a),
    .write_data        (write_data),
    .write_mask        (write_mask),
    .tick              (timer_tick),
    .load              (load_cmp),
    .count_value       (count_value),
    .top_value         (top_value),
    .counting_up       (dir_reg == DSPT_UP),
    .pwm_mode          (pwm_mode),
    .toggle_ok         (top_from_a),
    .output_mode       (cfg.output_mode_a),
    .pin_direction_bit (pin_direction_a),
    .compare_value_reg (cmp_a_int),
    .match             (match_a),
    .compare_output    (wave_a),
    .pin_out           (compare_output_a),
    .pin_oe            (compare_output_a_oe)
  );

  dspt_out_ch #(.WIDTH(16)) u_ch_b (
    .clock             (clock),
    .reset             (reset),
    .write_en          (compare_write_b),
    .write_data        (write_data),
    .write_mask        (write_mask),
    .tick              (timer_tick),
    .load              (load_cmp),
    .count_value       (count_value),
    .top_value         (top_value),
    .counting_up       (dir_reg == DSPT_UP),
    .pwm_mode          (pwm_mode),
    .toggle_ok         (1'b0),
    .output_mode       (cfg.output_mode_b),
    .pin_direction_bit (pin_direction_b),
    .compare_value_reg (cmp_b),
    .match             (match_b),
    .compare_output    (wave_b),
    .pin_out           (compare_output_b),
    .pin_oe            (compare_output_b_oe)
  );

  // Status copy of compare A
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      compare_value_a <= 16'h0000;
    end else begin
      compare_value_a <= cmp_a_int;
    end
  end

  // ----------------------------------------------------------------
  // Flags: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags <= '0; // [RULE23]
    end else begin
      flags.overflow_flag <= at_bottom || (flags.overflow_flag && !flag_clear.overflow_flag); // [RULE8] [RULE10]
      flags.compare_match_flag_a <= match_a || (top_from_a && at_top) ||
        (flags.compare_match_flag_a && !flag_clear.compare_match_flag_a); // [RULE9] [RULE11] [RULE17]
      flags.compare_match_flag_b <= match_b ||
        (flags.compare_match_flag_b && !flag_clear.compare_match_flag_b); // [RULE17]
      flags.capture_flag <= (top_from_cap && at_top) ||
        (flags.capture_flag && !flag_clear.capture_flag); // [RULE9] [RULE11]
    end
  end

  // Eight-bit timer tick passed out from a flop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_eight <= 1'b0;
    end else begin
      tick_eight <= ticks[1];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_top_hold;
    timer_tick && pwm_mode && dir_reg == DSPT_UP && count_value == top_value && top_value != 16'h0000;
  endsequence

  property p_hold_then_down;
    @(posedge clock) disable iff (reset)
      s_top_hold |=> (dir_reg == DSPT_HOLD && count_value == $past(count_value) - 16'h0001);
  endproperty
  a_hold_then_down: assert property (p_hold_then_down) else $error("no reversal at top"); // [RULE4]

  property p_no_tick_no_move;
    @(posedge clock) disable iff (reset)
      (!timer_tick && pwm_mode && $past(pwm_mode)) |=> $stable(count_value);
  endproperty
  a_no_tick_no_move: assert property (p_no_tick_no_move) else $error("counter moved without tick"); // [RULE20]

  property p_ovf_at_bottom;
    @(posedge clock) disable iff (reset)
      (pc_mode && timer_tick && count_value == BOTTOM) |=> flags.overflow_flag;
  endproperty
  a_ovf_at_bottom: assert property (p_ovf_at_bottom) else $error("overflow flag missed"); // [RULE8]

  property p_pc_load_top;
    @(posedge clock) disable iff (reset)
      (pc_mode && at_top) |=> cmp_b == $past(u_ch_b.buffer_reg);
  endproperty
  a_pc_load_top: assert property (p_pc_load_top) else $error("no load at top"); // [RULE9]

  property p_pfc_hold_off;
    @(posedge clock) disable iff (reset)
      (pfc_mode && !at_bottom && $past(pfc_mode)) |=> $stable(cmp_b);
  endproperty
  a_pfc_hold_off: assert property (p_pfc_hold_off) else $error("compare moved away from bottom"); // [RULE10]

  property p_cap_flag_top;
    @(posedge clock) disable iff (reset)
      (top_from_cap && at_top) |=> flags.capture_flag;
  endproperty
  a_cap_flag_top: assert property (p_cap_flag_top) else $error("capture flag missed at top"); // [RULE11]

  property p_noninv_up_clear;
    @(posedge clock) disable iff (reset)
      (match_b && cfg.output_mode_b == OM_NONINV && dir_reg == DSPT_UP && count_value != top_value) |=> !wave_b;
  endproperty
  a_noninv_up_clear: assert property (p_noninv_up_clear) else $error("non-inverted up match not low"); // [RULE6]

  property p_noninv_top_set;
    @(posedge clock) disable iff (reset)
      (match_b && cfg.output_mode_b == OM_NONINV && count_value == top_value) |=> wave_b;
  endproperty
  a_noninv_top_set: assert property (p_noninv_top_set) else $error("non-inverted match at top not high"); // [RULE14]

  property p_toggle_a;
    @(posedge clock) disable iff (reset)
      (match_a && cfg.output_mode_a == OM_TOGGLE && top_from_a) |=> wave_a != $past(wave_a);
  endproperty
  a_toggle_a: assert property (p_toggle_a) else $error("output A did not toggle"); // [RULE15]

  property p_pin_gate;
    @(posedge clock) disable iff (reset)
      !pin_direction_a |=> !compare_output_a_oe;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven without direction"); // [RULE16]

  property p_above_top;
    @(posedge clock) disable iff (reset)
      (cmp_b > top_value) |-> !match_b;
  endproperty
  a_above_top: assert property (p_above_top) else $error("match above top"); // [RULE13]

endmodule
